// file: rtl/mac_station_params.svh
// Offsets, field positions, reset values and sizes of the station address block.
`ifndef MAC_STATION_PARAMS_SVH
`define MAC_STATION_PARAMS_SVH

// ************************************************************
// Register byte offsets on the bus
// ************************************************************
`define MSA_OFF_ADDR0_LOW  8'h00
`define MSA_OFF_ADDR1_HIGH 8'h04
`define MSA_OFF_ADDR1_LOW  8'h08
`define MSA_OFF_CONFIG     8'h0C

// ************************************************************
// Field positions
// ************************************************************
`define MSA_AE_BIT      31
`define MSA_SA_BIT      30
`define MSA_MBC_HI      29
`define MSA_MBC_LO      24
`define MSA_RSVD_HI     23
`define MSA_RSVD_LO     16
`define MSA_UPPER_HI    15
`define MSA_UPPER_LO    0
`define MSA_CFG_DSYNC   0
`define MSA_CFG_BIGEND  1
`define MSA_CFG_BUSY    2
`define MSA_LANE_LE     3
`define MSA_LANE_BE     0

// ************************************************************
// Reset values and sizes
// ************************************************************
`define MSA_LOW_RST     32'hFFFF_FFFF
`define MSA_UPPER_RST   16'hFFFF
`define MSA_MASK_RST    6'h00
`define MSA_MASK_ALL    6'h3F
`define MSA_RSVD_VAL    8'h00
`define MSA_ADDR_BYTES  6
`define MSA_SYNC_STAGES 2

`endif

// file: rtl/mac_station_pkg.sv
// Types shared by the station address block and its byte matcher.
package mac_station_pkg;
	typedef logic [47:0] mac_addr_t;
	typedef logic [5:0]  byte_mask_t;
	typedef logic [31:0] word_t;
endpackage

// file: rtl/station_cmp_if.sv
// Carrier between the station register logic and the byte matcher.
`timescale 1ns/100ps
`default_nettype none
interface station_cmp_if;
	import mac_station_pkg::*;
	mac_addr_t  stored;
	mac_addr_t  frame;
	byte_mask_t mask;
	logic       enable;
	logic       hit;
	modport filter (output stored, output frame, output mask, output enable, input hit);
	modport matcher (input stored, input frame, input mask, input enable, output hit);
endinterface
`default_nettype wire

// file: rtl/station_match.sv
// Per-byte masked comparison of a frame address against a stored station address.
`timescale 1ns/100ps
`default_nettype none
`include "mac_station_params.svh"
module station_match (
	station_cmp_if.matcher cmp
);
	import mac_station_pkg::*;

	logic [`MSA_ADDR_BYTES-1:0] byteOk;

	// mask bit i excludes byte i, byte 0 being the first on the wire.
	genvar i;
	for (i = 0; i < `MSA_ADDR_BYTES; i = i + 1) begin : g_byte
		assign byteOk[i] = cmp.mask[i] | (cmp.frame[8*i +: 8] == cmp.stored[8*i +: 8]);
	end

	// hit only when enabled and every unmasked byte agrees.
	assign cmp.hit = cmp.enable & (&byteOk);
endmodule
`default_nettype wire

// file: rtl/mac_station_address_filter.sv
// Station address registers with Wishbone access, staged update and address-one filter.
//
// Notes on behaviour
// - Address-zero low word, resets ones, filter/pause.
// - Staged update starts only on trigger byte.
// - Address one filters only while enabled.
// - Selector picks source or destination field.
// - Each mask bit drops one address byte.
// - Match on unmasked bytes; mask resets zero.
// - High register bits 23:16 read zero.
// - Upper sixteen bits read-write, reset ones.
// - First received byte compares with bits 7:0.
`timescale 1ns/100ps
`default_nettype none
`include "mac_station_params.svh"
module mac_station_address_filter (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [7:0]            adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire mac_station_pkg::word_t dat_i,
	output var   mac_station_pkg::word_t dat_o,
	output logic                       ack_o,
	input  wire logic                  frameValid,
	input  wire mac_station_pkg::mac_addr_t frameDestAddr,
	input  wire mac_station_pkg::mac_addr_t frameSrcAddr,
	output var   mac_station_pkg::word_t station0Low,
	output logic                       station1Hit,
	output logic                       hitValid
);
	import mac_station_pkg::*;

	// ************************************************************
	// Software-visible registers and their staged copies
	// ************************************************************
	word_t       addr0Low;
	logic [15:0] addr1Upper;
	logic        addr1Enable;
	logic        addr1SrcSel;
	byte_mask_t  addr1Mask;
	word_t       addr1Low;
	logic        doubleSync;
	logic        bigEndian;
	logic [15:0] shUpper;
	logic        shEnable;
	logic        shSrcSel;
	byte_mask_t  shMask;
	word_t       shLow;
	logic [`MSA_SYNC_STAGES-1:0] syncPipe;
	word_t       readWord;
	word_t       highWord;
	word_t       merged;
	logic        commit;
	logic        syncStart;
	mac_addr_t   selField;

	station_cmp_if cmp ();

	// Merges write data into an old word under the byte enables.
	function automatic word_t laneMerge(input word_t oldWord, input word_t newWord,
		input logic [3:0] sel);
		word_t r;
		r = oldWord;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = newWord[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ************************************************************
	// Wishbone slave
	// ************************************************************

	// The write lands on the edge where the master sees ack, never earlier.
	assign commit = cyc_i & stb_i & we_i & ack_o;

	// Ack rises one cycle after the request and drops the cycle after.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
		end
	end

	// reserved bits of the high word always read as zero.
	assign highWord = {addr1Enable, addr1SrcSel, addr1Mask, `MSA_RSVD_VAL, addr1Upper};

	// Read multiplexer; unmapped offsets read zero.
	always_comb begin
		case (adr_i)
			`MSA_OFF_ADDR0_LOW:  readWord = addr0Low;
			`MSA_OFF_ADDR1_HIGH: readWord = highWord;
			`MSA_OFF_ADDR1_LOW:  readWord = addr1Low;
			`MSA_OFF_CONFIG:     readWord = {29'h0, |syncPipe, bigEndian, doubleSync};
			default:             readWord = 32'h0000_0000;
		endcase
	end

	// Read data is captured as ack rises and stays until the next read.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i & stb_i & ~we_i & ~ack_o) begin
			dat_o <= readWord;
		end
	end

	assign merged = laneMerge(adr_i == `MSA_OFF_ADDR1_HIGH ? highWord :
		adr_i == `MSA_OFF_ADDR1_LOW ? addr1Low :
		adr_i == `MSA_OFF_CONFIG ? readWord : addr0Low, dat_i, sel_i);

	// address-zero low word, all ones out of reset.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr0Low <= `MSA_LOW_RST;
		end else if (commit && adr_i == `MSA_OFF_ADDR0_LOW) begin
			addr0Low <= merged;
		end
	end

	// address-one high word; mask resets to zero.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr1Upper  <= `MSA_UPPER_RST;
			addr1Enable <= 1'b0;
			addr1SrcSel <= 1'b0;
			addr1Mask   <= `MSA_MASK_RST;
		end else if (commit && adr_i == `MSA_OFF_ADDR1_HIGH) begin
			addr1Upper  <= merged[`MSA_UPPER_HI:`MSA_UPPER_LO];
			addr1Enable <= merged[`MSA_AE_BIT];
			addr1SrcSel <= merged[`MSA_SA_BIT];
			addr1Mask   <= merged[`MSA_MBC_HI:`MSA_MBC_LO];
		end
	end

	// Address-one low word; holds ones until software loads it.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr1Low <= `MSA_LOW_RST;
		end else if (commit && adr_i == `MSA_OFF_ADDR1_LOW) begin
			addr1Low <= merged;
		end
	end

	// Staging mode and byte order.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			doubleSync <= 1'b0;
			bigEndian  <= 1'b0;
		end else if (commit && adr_i == `MSA_OFF_CONFIG) begin
			doubleSync <= merged[`MSA_CFG_DSYNC];
			bigEndian  <= merged[`MSA_CFG_BIGEND];
		end
	end

	// ************************************************************
	// Staged update of the consumer copies
	// ************************************************************

	// only the trigger byte lane of a low-word write starts a transfer.
	assign syncStart = doubleSync & commit &
		(adr_i == `MSA_OFF_ADDR0_LOW | adr_i == `MSA_OFF_ADDR1_LOW) &
		(bigEndian ? sel_i[`MSA_LANE_BE] : sel_i[`MSA_LANE_LE]);

	// a later trigger inside the window enters the stages behind the earlier one, which still completes.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncPipe <= '0;
		end else begin
			syncPipe <= {syncPipe[`MSA_SYNC_STAGES-2:0], syncStart};
		end
	end

	// consumer copies follow live values directly or at the last stage.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			station0Low <= `MSA_LOW_RST;
			shUpper     <= `MSA_UPPER_RST;
			shEnable    <= 1'b0;
			shSrcSel    <= 1'b0;
			shMask      <= `MSA_MASK_RST;
			shLow       <= `MSA_LOW_RST;
		end else if (!doubleSync || syncPipe[`MSA_SYNC_STAGES-1]) begin
			station0Low <= addr0Low;
			shUpper     <= addr1Upper;
			shEnable    <= addr1Enable;
			shSrcSel    <= addr1SrcSel;
			shMask      <= addr1Mask;
			shLow       <= addr1Low;
		end
	end

	// ************************************************************
	// Address-one perfect filter
	// ************************************************************

	// the selector chooses which frame field is compared.
	assign selField = shSrcSel ? frameSrcAddr : frameDestAddr;

	// stored low word byte 0 lines up with the first received byte.
	assign cmp.stored = {shUpper, shLow};
	assign cmp.frame  = selField;
	assign cmp.mask   = shMask;
	assign cmp.enable = shEnable;

	station_match u_match (
		.cmp (cmp.matcher)
	);

	// a disabled address never hits; the verdict is registered.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			station1Hit <= 1'b0;
			hitValid    <= 1'b0;
		end else begin
			hitValid    <= frameValid;
			station1Hit <= frameValid & cmp.hit;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	a_addr0_direct: assert property (!doubleSync ##1 !doubleSync |->
		station0Low == $past(addr0Low)) else $error("address zero copy lags");
	a_sync_hold: assert property (doubleSync && !syncPipe[1] |=>
		$stable(station0Low)) else $error("copy changed without trigger");
	a_sync_delay: assert property (syncStart |-> ##2 syncPipe[1])
		else $error("staged update not started");
	a_enable_gate: assert property (frameValid && !shEnable |=>
		hitValid && !station1Hit) else $error("disabled address hit");
	a_full_match: assert property (frameValid && shEnable && shMask == `MSA_MASK_RST &&
		selField == {shUpper, shLow} |=> station1Hit) else $error("exact match missed");
	a_byte_mask: assert property (frameValid && shEnable && shMask == 6'h01 &&
		selField[47:32] == shUpper[15:0] && selField[31:8] == shLow[31:8]
		|=> station1Hit) else $error("masked byte still compared");
	a_mask_all: assert property (frameValid && shEnable && shMask == `MSA_MASK_ALL
		|=> station1Hit) else $error("fully masked address missed");
	a_mismatch: assert property (frameValid && shMask == `MSA_MASK_RST &&
		selField != {shUpper, shLow} |=> !station1Hit) else $error("false hit");
	a_rsvd_zero: assert property (ack_o && !we_i && adr_i == `MSA_OFF_ADDR1_HIGH |->
		dat_o[23:16] == `MSA_RSVD_VAL) else $error("reserved bits nonzero");
	a_upper_reset: assert property ($past(srst) |-> addr1Upper == `MSA_UPPER_RST)
		else $error("upper address reset wrong");
endmodule
`default_nettype wire

// file: tb/frame_source.sv
// Receive-side model that presents frame addresses to the filter.
`timescale 1ns/100ps
`default_nettype none
module frame_source (
	input  wire logic                       core_clk,
	input  wire logic                       hitValid,
	input  wire logic                       station1Hit,
	output var logic                        frameValid,
	output var mac_station_pkg::mac_addr_t  frameDestAddr,
	output var mac_station_pkg::mac_addr_t  frameSrcAddr
);
	import mac_station_pkg::*;
	// Fields are inverted after each frame so stale values never look valid.
	task automatic send(input mac_addr_t d, input mac_addr_t s, output logic hit,
		output logic vld);
		@(posedge core_clk);
		frameValid <= 1'b1;
		frameDestAddr <= d;
		frameSrcAddr <= s;
		@(posedge core_clk);
		frameValid <= 1'b0;
		frameDestAddr <= ~d;
		frameSrcAddr <= ~s;
		@(negedge core_clk);
		vld = hitValid;
		hit = station1Hit;
	endtask
	// Idle at time zero.
	initial begin
		frameValid = 1'b0;
		frameDestAddr = '0;
		frameSrcAddr = '0;
	end
endmodule
`default_nettype wire

// file: tb/mac_station_address_filter_bench.sv
// Self-checking bench for the station address registers and filter.
`timescale 1ns/100ps
`default_nettype none
module mac_station_address_filter_bench;
	import mac_station_pkg::*;
	logic core_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	word_t wdat = '0, rdat, station0Low;
	logic ack, station1Hit, hitValid, frameValid, hit, vld;
	mac_addr_t frameDestAddr, frameSrcAddr;
	mac_addr_t addrA = 48'h6655_4433_2211;
	int fails = 0, total_checks = 0;
	mac_station_address_filter uut (.core_clk(core_clk), .srst(srst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.frameValid(frameValid), .frameDestAddr(frameDestAddr), .frameSrcAddr(frameSrcAddr),
		.station0Low(station0Low), .station1Hit(station1Hit), .hitValid(hitValid));
	frame_source fs (.core_clk(core_clk), .hitValid(hitValid), .station1Hit(station1Hit),
		.frameValid(frameValid), .frameDestAddr(frameDestAddr), .frameSrcAddr(frameSrcAddr));
	// 20 MHz clock.
	always #25 core_clk = ~core_clk;
	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input string nm, input word_t e, input word_t g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic cycle; held until ack is sampled, then released for a cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input word_t d,
		output word_t r);
		int n;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = rdat;
		if (n >= 20) chk("ack", 1, 0);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] s, input word_t d);
		word_t r;
		wb(1'b1, a, s, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input word_t e, input string nm);
		word_t r;
		wb(1'b0, a, 4'hF, '0, r);
		chk(nm, e, r);
	endtask
	task automatic frm(input mac_addr_t d, input mac_addr_t s, input logic e, input string nm);
		fs.send(d, s, hit, vld);
		chk("hitValid", 1, {31'h0, vld});
		chk(nm, {31'h0, e}, {31'h0, hit});
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run length.
	initial begin
		#2000000;
		fails++;
		print_verdict();
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'h00, 32'hFFFF_FFFF, "addr0 low reset");
		chk("copy reset", 32'hFFFF_FFFF, station0Low);
		rd(8'h04, 32'h0000_FFFF, "addr1 high reset");
		rd(8'h08, 32'hFFFF_FFFF, "addr1 low reset");
		wr(8'h04, 4'hF, 32'h3FFF_ABCD);
		rd(8'h04, 32'h3F00_ABCD, "reserved zero");
		// Every byte masked: any address hits once the entry is enabled.
		wr(8'h04, 4'hF, 32'hBF00_ABCD);
		frm(~addrA, ~addrA, 1'b1, "all masked");
		wr(8'h10, 4'hF, 32'h1234_5678);
		rd(8'h10, 32'h0, "unmapped");
		// Address one loaded but disabled, then enabled against the destination field.
		wr(8'h08, 4'hF, 32'h4433_2211);
		wr(8'h04, 4'hF, 32'h0000_6655);
		frm(addrA, ~addrA, 1'b0, "disabled");
		wr(8'h04, 4'hF, 32'h8000_6655);
		frm(addrA, ~addrA, 1'b1, "dest hit");
		frm(~addrA, addrA, 1'b0, "dest only");
		wr(8'h04, 4'hF, 32'hC000_6655);
		frm(~addrA, addrA, 1'b1, "source hit");
		// Each byte differs in turn: miss unmasked, hit with its mask bit.
		for (int i = 0; i < 6; i++) begin
			wr(8'h04, 4'hF, 32'h8000_6655);
			frm(addrA ^ (48'hFF << (8 * i)), ~addrA, 1'b0, "unmasked byte");
			wr(8'h04, 4'hF, 32'h8000_6655 | (32'h1 << (24 + i)));
			frm(addrA ^ (48'hFF << (8 * i)), ~addrA, 1'b1, "masked byte");
		end
		// Staged copy in little-endian mode: only the top lane starts it.
		wr(8'h0C, 4'hF, 32'h1);
		wr(8'h00, 4'h7, 32'h0102_0304);
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		chk("no trigger le", 32'hFFFF_FFFF, station0Low);
		wr(8'h00, 4'h8, 32'h0102_0304);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk("trigger le", 32'h0102_0304, station0Low);
		// Big-endian mode: lane zero starts it, top lane does not.
		wr(8'h0C, 4'hF, 32'h3);
		wr(8'h00, 4'h8, 32'hAA02_0304);
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		chk("no trigger be", 32'h0102_0304, station0Low);
		wr(8'h00, 4'h1, 32'hAA02_0355);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk("trigger be", 32'hAA02_0355, station0Low);
		rd(8'h00, 32'hAA02_0355, "addr0 low rw");
		// Reset in mid-run must drop the staging mode and restore all ones.
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'h0C, 32'h0, "config after reset");
		chk("copy after reset", 32'hFFFF_FFFF, station0Low);
		rd(8'h00, 32'hFFFF_FFFF, "addr0 low after reset");
		print_verdict();
	end
endmodule
`default_nettype wire
